// ==== rtl/tmcc_top.sv ====
// Channel mode and compare control with its AHB-Lite register slave.
//
// Behaviour
// - The mode control register resets to all zeros: outputs, timing mode.
// - A channel's mode field is written only while that channel is disabled.
// - Channel 0 mode: output, own input, channel 1 input, internal trigger.
// - Channel 1 mode: output, own input, channel 0 input, internal trigger.
// - Compare field drives an active-high prepared output; pins follow polarity.
// - Timing mode keeps the prepared output steady.
// - On match: set, clear or toggle the prepared output.
// - Force low and force high hold the prepared output regardless of counter.
// - First PWM mode: high below compare counting up, low above counting down.
// - Second PWM mode is the inverse of the first.
// - PWM output changes only on comparison change or entry from timing.
// - Shadow enable sends compare writes to a copy loaded at update.
// - Fast enable in PWM makes a trigger edge act as a match.
// - Channel 1 has the same compare, shadow and fast fields higher up.
// - In input mode the bits read as capture filter and divider.
// - Channel enable bits sit in a separate register and lock the mode.
module tmcc_top
  import tmcc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [11:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Timer counter side
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic             count_en,
  input  wire logic             count_down,
  input  wire logic             update_evt,
  input  wire logic             trigger_edge,
  // Channel input sources
  input  wire logic             filtered_in0_to_chan0,
  input  wire logic             filtered_in1_to_chan0,
  input  wire logic             filtered_in1_to_chan1,
  input  wire logic             filtered_in0_to_chan1,
  input  wire logic             internal_trigger_sel,
  // Channel 0 results
  output logic                  chan0_prepared_out,
  output logic                  chan0_out_pin,
  output logic                  chan0_comp_out_pin,
  output logic                  chan0_input_sel,
  output logic [3:0]            chan0_capture_filter,
  output logic [1:0]            chan0_capture_divider,
  // Channel 1 results
  output logic                  chan1_prepared_out,
  output logic                  chan1_out_pin,
  output logic                  chan1_comp_out_pin,
  output logic                  chan1_input_sel,
  output logic [3:0]            chan1_capture_filter,
  output logic [1:0]            chan1_capture_divider
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mode_reg;
    logic [31:0] en_reg;
    tmcc_bus_t   bus;
    logic [11:0] addr;
    logic [31:0] rdata;
  } tmcc_top_st_t;

  tmcc_top_st_t     q;
  tmcc_top_st_t     d;
  logic             addr_take;
  logic             wr_word;
  logic [31:0]      wr_val;
  logic [31:0]      rd_mux;
  logic             cv0_wr;
  logic             cv1_wr;
  logic [CNT_W-1:0] cv0_act;
  logic [CNT_W-1:0] cv0_shd;
  logic [CNT_W-1:0] cv1_act;
  logic [CNT_W-1:0] cv1_shd;
  logic [1:0]       dir0;
  logic [1:0]       dir1;

  assign dir0 = q.mode_reg[CH0_DIR_LSB +: 2];
  assign dir1 = q.mode_reg[CH1_DIR_LSB +: 2];

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb
  begin
    case (q.addr)
      OFS_CHAN_MODE: rd_mux = q.mode_reg;
      OFS_CHAN_EN:   rd_mux = q.en_reg;
      OFS_CV0:       rd_mux = 32'(cv0_shd);
      OFS_CV1:       rd_mux = 32'(cv1_shd);
      default:       rd_mux = RST_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    d         = q;
    addr_take = hsel && htrans[1] && hready;
    wr_word   = (q.bus == BUS_WRITE);
    wr_val    = hwdata;
    cv0_wr    = wr_word && (q.addr == OFS_CV0);
    cv1_wr    = wr_word && (q.addr == OFS_CV1);
    if (wr_word && (q.addr == OFS_CHAN_MODE))
    begin
      wr_val = hwdata & CHAN_MODE_MSK;
      if (q.en_reg[EN0_BIT])
      begin
        wr_val[CH0_DIR_LSB +: 2] = dir0;
      end
      if (q.en_reg[EN1_BIT])
      begin
        wr_val[CH1_DIR_LSB +: 2] = dir1;
      end
      d.mode_reg = wr_val;
    end
    if (wr_word && (q.addr == OFS_CHAN_EN))
    begin
      d.en_reg = hwdata & CHAN_EN_MSK;
    end
    case (q.bus)
      BUS_READ:
      begin
        d.rdata = rd_mux;
        d.bus   = BUS_READ_OUT;
      end
      BUS_IDLE, BUS_WRITE, BUS_READ_OUT:
      begin
        d.bus = BUS_IDLE;
        if (addr_take)
        begin
          d.addr = haddr;
          if (hwrite && (hsize == HSIZE_WORD))
          begin
            d.bus = BUS_WRITE;
          end
          else if (!hwrite)
          begin
            d.bus = BUS_READ;
          end
        end
      end
      default: d.bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q.mode_reg <= RST_ZERO;
      q.en_reg   <= RST_ZERO;
      q.bus      <= BUS_IDLE;
      q.addr     <= 12'h000;
      q.rdata    <= RST_ZERO;
    end
    else
    begin
      q <= d;
    end
  end

  assign hrdata    = q.rdata;
  assign hreadyout = (q.bus != BUS_READ);
  assign hresp     = HRESP_OKAY;

  // ----------------------------------------------------------------
  // Input mode views
  // ----------------------------------------------------------------
  assign chan0_capture_filter  = q.mode_reg[CH0_FLT_LSB +: 4];
  assign chan0_capture_divider = q.mode_reg[CH0_DIV_LSB +: 2];
  assign chan1_capture_filter  = q.mode_reg[CH1_FLT_LSB +: 4];
  assign chan1_capture_divider = q.mode_reg[CH1_DIV_LSB +: 2];

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  tmcc_chan #(
    .CNT_W (CNT_W)
  ) u_chan0 (
    .clk           (clk),
    .srst          (srst),
    .dir_sel       (dir0),
    .cmp_sel       (q.mode_reg[CH0_CMP_LSB +: 3]),
    .preload_on    (q.mode_reg[CH0_PRE_BIT]),
    .fast_on       (q.mode_reg[CH0_FAST_BIT]),
    .chan_enable   (q.en_reg[EN0_BIT]),
    .polarity      (q.en_reg[POL0_BIT]),
    .comp_polarity (q.en_reg[NPOL0_BIT]),
    .cv_wr         (cv0_wr),
    .cv_wdata      (hwdata[CNT_W-1:0]),
    .counter       (counter_value),
    .count_en      (count_en),
    .count_down    (count_down),
    .update_evt    (update_evt),
    .trig_edge     (trigger_edge),
    .own_in        (filtered_in0_to_chan0),
    .cross_in      (filtered_in1_to_chan0),
    .trig_in       (internal_trigger_sel),
    .cv_active     (cv0_act),
    .cv_shadow     (cv0_shd),
    .prepared_out  (chan0_prepared_out),
    .out_pin       (chan0_out_pin),
    .comp_out_pin  (chan0_comp_out_pin),
    .input_sel     (chan0_input_sel)
  );

  tmcc_chan #(
    .CNT_W (CNT_W)
  ) u_chan1 (
    .clk           (clk),
    .srst          (srst),
    .dir_sel       (dir1),
    .cmp_sel       (q.mode_reg[CH1_CMP_LSB +: 3]),
    .preload_on    (q.mode_reg[CH1_PRE_BIT]),
    .fast_on       (q.mode_reg[CH1_FAST_BIT]),
    .chan_enable   (q.en_reg[EN1_BIT]),
    .polarity      (q.en_reg[POL1_BIT]),
    .comp_polarity (q.en_reg[NPOL1_BIT]),
    .cv_wr         (cv1_wr),
    .cv_wdata      (hwdata[CNT_W-1:0]),
    .counter       (counter_value),
    .count_en      (count_en),
    .count_down    (count_down),
    .update_evt    (update_evt),
    .trig_edge     (trigger_edge),
    .own_in        (filtered_in1_to_chan1),
    .cross_in      (filtered_in0_to_chan1),
    .trig_in       (internal_trigger_sel),
    .cv_active     (cv1_act),
    .cv_shadow     (cv1_shd),
    .prepared_out  (chan1_prepared_out),
    .out_pin       (chan1_out_pin),
    .comp_out_pin  (chan1_comp_out_pin),
    .input_sel     (chan1_input_sel)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_mode_write;
    q.bus == BUS_WRITE && q.addr == OFS_CHAN_MODE;
  endsequence

  a_reset_clear: assert property ($past(srst) |-> q.mode_reg == RST_ZERO && q.en_reg == RST_ZERO)
    else $error("Registers not zero after reset.");
  a_dir0_locked: assert property (s_mode_write and q.en_reg[EN0_BIT] |=> $stable(dir0))
    else $error("Channel 0 mode changed while enabled.");
  a_dir1_locked: assert property (s_mode_write and q.en_reg[EN1_BIT] |=> $stable(dir1))
    else $error("Channel 1 mode changed while enabled.");
  a_dir0_open: assert property (s_mode_write and !q.en_reg[EN0_BIT]
                                |=> dir0 == $past(hwdata[CH0_DIR_LSB +: 2]))
    else $error("Channel 0 mode write was lost while disabled.");
  a_narrow_dropped: assert property (hsel && htrans[1] && hready && hwrite && hsize != HSIZE_WORD
                                     |=> q.bus == BUS_IDLE)
    else $error("A narrow write was accepted.");
  a_read_wait: assert property (q.bus == BUS_READ |-> !hreadyout ##1 hreadyout && hrdata == $past(rd_mux))
    else $error("Read data did not follow one wait state.");
  a_input_own0: assert property (dir0 == DIR_IN_OWN |=> chan0_input_sel == $past(filtered_in0_to_chan0))
    else $error("Channel 0 own input not selected.");
  a_input_cross1: assert property (dir1 == DIR_IN_CROSS |=> chan1_input_sel == $past(filtered_in0_to_chan1))
    else $error("Channel 1 cross input not selected.");
  a_pin_idle: assert property (!q.en_reg[EN0_BIT] |=> !chan0_out_pin && !chan0_comp_out_pin)
    else $error("Channel 0 pins driven while disabled.");

endmodule : tmcc_top

// ==== rtl/tmcc_pkg.sv ====
// Shared constants and types of the channel mode and compare control block.
package tmcc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CHAN_MODE = 12'h018;
  localparam logic [11:0] OFS_CHAN_EN   = 12'h020;
  localparam logic [11:0] OFS_CV0       = 12'h034;
  localparam logic [11:0] OFS_CV1       = 12'h038;
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [31:0] CHAN_MODE_MSK = 32'h0000_7f7f;
  localparam logic [31:0] CHAN_EN_MSK   = 32'h0000_00bb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CH0_DIR_LSB  = 0;
  localparam int CH0_FAST_BIT = 2;
  localparam int CH0_DIV_LSB  = 2;
  localparam int CH0_PRE_BIT  = 3;
  localparam int CH0_CMP_LSB  = 4;
  localparam int CH0_FLT_LSB  = 4;
  localparam int CH1_DIR_LSB  = 8;
  localparam int CH1_FAST_BIT = 10;
  localparam int CH1_DIV_LSB  = 10;
  localparam int CH1_PRE_BIT  = 11;
  localparam int CH1_CMP_LSB  = 12;
  localparam int CH1_FLT_LSB  = 12;
  localparam int EN0_BIT      = 0;
  localparam int POL0_BIT     = 1;
  localparam int NPOL0_BIT    = 3;
  localparam int EN1_BIT      = 4;
  localparam int POL1_BIT     = 5;
  localparam int NPOL1_BIT    = 7;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic       HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DIR_OUT      = 2'b00,
    DIR_IN_OWN   = 2'b01,
    DIR_IN_CROSS = 2'b10,
    DIR_IN_TRIG  = 2'b11
  } tmcc_dir_t;

  typedef enum logic [2:0] {
    CMP_TIMING   = 3'b000,
    CMP_SET      = 3'b001,
    CMP_CLR      = 3'b010,
    CMP_TOGGLE   = 3'b011,
    CMP_FORCE_LO = 3'b100,
    CMP_FORCE_HI = 3'b101,
    CMP_PWM0     = 3'b110,
    CMP_PWM1     = 3'b111
  } tmcc_cmp_t;

  typedef enum logic [1:0] {
    BUS_IDLE     = 2'b00,
    BUS_WRITE    = 2'b01,
    BUS_READ     = 2'b10,
    BUS_READ_OUT = 2'b11
  } tmcc_bus_t;

endpackage : tmcc_pkg

// ==== rtl/tmcc_chan.sv ====
// One capture/compare channel: compare value shadowing, prepared output and pins.
module tmcc_chan
  import tmcc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Configuration
  input  wire logic [1:0]       dir_sel,
  input  wire logic [2:0]       cmp_sel,
  input  wire logic             preload_on,
  input  wire logic             fast_on,
  input  wire logic             chan_enable,
  input  wire logic             polarity,
  input  wire logic             comp_polarity,
  // Compare value write
  input  wire logic             cv_wr,
  input  wire logic [CNT_W-1:0] cv_wdata,
  // Counter side
  input  wire logic [CNT_W-1:0] counter,
  input  wire logic             count_en,
  input  wire logic             count_down,
  input  wire logic             update_evt,
  input  wire logic             trig_edge,
  // Input sources
  input  wire logic             own_in,
  input  wire logic             cross_in,
  input  wire logic             trig_in,
  // Results
  output logic [CNT_W-1:0]      cv_active,
  output logic [CNT_W-1:0]      cv_shadow,
  output logic                  prepared_out,
  output logic                  out_pin,
  output logic                  comp_out_pin,
  output logic                  input_sel
);

  typedef struct packed {
    logic [CNT_W-1:0] cv_act;
    logic [CNT_W-1:0] cv_shd;
    logic             prep;
    logic             lvl;
    logic [2:0]       mode;
    logic             pin;
    logic             cpin;
    logic             isel;
  } tmcc_chan_st_t;

  tmcc_chan_st_t q;
  tmcc_chan_st_t d;
  logic          match;
  logic          is_out;
  logic          pwm_lvl;
  logic          fast_lvl;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    is_out   = (dir_sel == DIR_OUT);
    match    = count_en && (counter == q.cv_act);
    pwm_lvl  = count_down ? !(counter > q.cv_act) : (counter < q.cv_act);
    if (cmp_sel == CMP_PWM1)
    begin
      pwm_lvl = !pwm_lvl;
    end
    fast_lvl = (cmp_sel == CMP_PWM1) ^ count_down;
    if (cv_wr)
    begin
      d.cv_shd = cv_wdata;
      if (!preload_on)
      begin
        d.cv_act = cv_wdata;
      end
    end
    if (update_evt && preload_on)
    begin
      d.cv_act = q.cv_shd;
    end
    if (count_en)
    begin
      d.lvl = pwm_lvl;
    end
    d.mode = cmp_sel;
    if (is_out)
    begin
      case (cmp_sel)
        CMP_TIMING:   d.prep = q.prep;
        CMP_SET:      if (match) d.prep = 1'b1;
        CMP_CLR:      if (match) d.prep = 1'b0;
        CMP_TOGGLE:   if (match) d.prep = !q.prep;
        CMP_FORCE_LO: d.prep = 1'b0;
        CMP_FORCE_HI: d.prep = 1'b1;
        default:
        begin
          if (q.mode == CMP_TIMING)
          begin
            d.prep = pwm_lvl;
          end
          else if (count_en && (pwm_lvl != q.lvl))
          begin
            d.prep = pwm_lvl;
          end
          if (fast_on && trig_edge)
          begin
            d.prep = fast_lvl;
          end
        end
      endcase
    end
    d.pin  = chan_enable && is_out && (d.prep ^ polarity);
    d.cpin = chan_enable && is_out && (!d.prep ^ comp_polarity);
    case (dir_sel)
      DIR_IN_OWN:   d.isel = own_in;
      DIR_IN_CROSS: d.isel = cross_in;
      DIR_IN_TRIG:  d.isel = trig_in;
      default:      d.isel = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign cv_active    = q.cv_act;
  assign cv_shadow    = q.cv_shd;
  assign prepared_out = q.prep;
  assign out_pin      = q.pin;
  assign comp_out_pin = q.cpin;
  assign input_sel    = q.isel;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_shadow_wr;
    cv_wr && preload_on;
  endsequence

  sequence s_clean_update;
    update_evt && preload_on && !cv_wr;
  endsequence

  a_force_low_hold: assert property (is_out && cmp_sel == CMP_FORCE_LO |=> !prepared_out)
    else $error("Force low mode did not drive the prepared output low.");
  a_set_on_match: assert property (is_out && cmp_sel == CMP_SET && match |=> prepared_out)
    else $error("Set mode did not drive the prepared output high on a match.");
  a_toggle_on_match: assert property (is_out && cmp_sel == CMP_TOGGLE && match
                                      |=> prepared_out != $past(prepared_out))
    else $error("Toggle mode did not invert the prepared output on a match.");
  a_timing_steady: assert property (is_out && cmp_sel == CMP_TIMING |=> $stable(prepared_out))
    else $error("Timing mode changed the prepared output.");
  a_direct_write: assert property (cv_wr && !preload_on && !update_evt |=> cv_active == $past(cv_wdata))
    else $error("Direct compare write did not take effect.");
  a_shadow_load: assert property (s_shadow_wr ##1 s_clean_update |=> cv_active == $past(cv_wdata, 2))
    else $error("Shadow value was not loaded at the update event.");
  a_fast_trigger: assert property (is_out && cmp_sel[2:1] == 2'b11 && fast_on && trig_edge
                                   |=> prepared_out == $past(fast_lvl))
    else $error("Fast trigger did not force the compare level.");

endmodule : tmcc_chan

// ==== verification/tmcc_cnt_model.sv ====
// Model of the timer counter, update event and trigger that feed the channels.
module tmcc_cnt_model
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Counter side
  output logic [15:0] counter,
  output logic        count_en,
  output logic        count_down,
  output logic        update_evt,
  output logic        trig_edge
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Up counter wrapping at 15
  // ----------------------------------------------------------------
  assign count_down = 1'b0;
  assign trig_edge  = 1'b0;
  assign update_evt = count_en && (counter == 16'h000f);
  always_ff @(posedge clk)
  begin
    count_en <= !srst;
    counter  <= srst ? 16'h0000 : ((counter + 16'h0001) & 16'h000f);
  end
endmodule : tmcc_cnt_model

// ==== verification/timer_channel_mode_compare_ctl_test.sv ====
// Self-checking bench of the channel mode and compare control block.
module timer_channel_mode_compare_ctl_test import tmcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, hsel, hwrite, hready, hreadyout, hresp, cen, cdn, upd, trg, e;
  logic        p0, o0, n0, s0, p1, o1, n1, s1;
  logic [11:0] haddr;
  logic [1:0]  htrans, div0, div1;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, v;
  logic [15:0] cnt, lfsr_q, cv, c;
  logic [4:0]  ins;
  logic [3:0]  flt0, flt1;
  logic [2:0]  modes [8] = '{3'h5, 3'h0, 3'h2, 3'h0, 3'h1, 3'h4, 3'h6, 3'h7};
  int          err_total, checked;
  assign hready = hreadyout;
  tmcc_cnt_model cnt_u (.clk(clk), .srst(srst), .counter(cnt), .count_en(cen), .count_down(cdn),
    .update_evt(upd), .trig_edge(trg));
  tmcc_top dut_u (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .counter_value(cnt), .count_en(cen), .count_down(cdn), .update_evt(upd), .trigger_edge(trg),
    .filtered_in0_to_chan0(ins[0]), .filtered_in1_to_chan0(ins[1]), .filtered_in1_to_chan1(ins[2]),
    .filtered_in0_to_chan1(ins[3]), .internal_trigger_sel(ins[4]), .chan0_prepared_out(p0),
    .chan0_out_pin(o0), .chan0_comp_out_pin(n0), .chan0_input_sel(s0), .chan0_capture_filter(flt0),
    .chan0_capture_divider(div0), .chan1_prepared_out(p1), .chan1_out_pin(o1), .chan1_comp_out_pin(n1),
    .chan1_input_sel(s1), .chan1_capture_filter(flt1), .chan1_capture_divider(div1));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic give_verdict();
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    srst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 12'h000;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    ins = 5'h00;
    lfsr_q = 16'hc4b5;
    err_total = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    bus(OFS_CHAN_MODE, 1'b0, 32'h0);
    chk(rd, RST_ZERO);
    lfsr_q = lfsr_next(lfsr_q);
    v = {16'h0000, lfsr_q} & CHAN_MODE_MSK;
    bus(OFS_CHAN_MODE, 1'b1, v);
    bus(OFS_CHAN_MODE, 1'b0, 32'h0);
    chk(rd, v);
    chk({28'h0, flt0, div1}, {28'h0, v[7:4], v[11:10]});
    chk({28'h0, flt1, div0}, {28'h0, v[15:12], v[3:2]});
    bus(12'h0fc, 1'b0, 32'h0);
    chk({rd[31:1], hresp}, {31'h0, HRESP_OKAY});
    bus(OFS_CHAN_MODE, 1'b1, 32'h0);
    bus(OFS_CHAN_EN, 1'b1, 32'h1);
    bus(OFS_CHAN_MODE, 1'b1, 32'h51);
    bus(OFS_CHAN_MODE, 1'b0, 32'h0);
    chk(rd, 32'h50);
    e = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      cv = 16'h0001 + lfsr_q % 16'd14;
      bus(OFS_CV0, 1'b1, {16'h0000, cv});
      bus(OFS_CHAN_MODE, 1'b1, {25'h0, modes[i], 4'h8});
      repeat (20) @(posedge clk);
      repeat (8)
      begin
        @(negedge clk);
        c = cnt;
        @(negedge clk);
        case (modes[i])
          3'h1, 3'h5: e = 1'b1;
          3'h2, 3'h4: e = 1'b0;
          3'h6: e = c < cv;
          3'h7: e = !(c < cv);
          default: e = e;
        endcase
        chk({29'h0, p0, o0, n0}, {29'h0, e, e, !e});
        chk({29'h0, p1, o1, n1}, 32'h0);
        chk({31'h0, s0}, 32'h0);
      end
    end
    for (int d = 1; d < 4; d++)
    begin
      bus(OFS_CHAN_MODE, 1'b1, 32'(d << 8));
      ins <= 5'h01 << (d + 1);
      repeat (3) @(negedge clk);
      chk({31'h0, s1}, 32'h1);
      @(posedge clk);
      ins <= ~(5'h01 << (d + 1));
      repeat (3) @(negedge clk);
      chk({31'h0, s1}, 32'h0);
    end
    give_verdict();
  end
endmodule : timer_channel_mode_compare_ctl_test
